/* hw/sdc_dac_ctrl.sv */
module sdc_dac_ctrl (
    input wire logic sys_clk, // System clock, 40 MHz
    input wire logic rstn, // Synchronous reset, active low
    input wire logic serialClk, // Serial clock pin
    input wire logic chipSelectN, // Chip select pin, active low
    input wire logic serialInLine, // Serial data pin
    input wire logic midscalePresetN, // Midscale preset pin, active low
    input wire logic powerDownN, // Shutdown pin, active low
    output sdc_pkg::sdc_codes_t channelCode, // Channel code registers
    output logic [sdc_pkg::NUM_CHANNELS-1:0] outputEnable, // High: output driven
    output logic [sdc_pkg::NUM_CHANNELS-1:0] loadPulse // One-cycle load per channel
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    sdc_pkg::sdc_link_t pinLevel;
    sdc_pkg::sdc_link_t lvl;
    logic clkRise;
    logic csRise;
    sdc_pkg::sdc_frame_t frameState;
    sdc_pkg::sdc_frame_t next_frameState;
    sdc_pkg::sdc_word_t shiftWord;
    logic [sdc_pkg::ADDR_BITS-1:0] bitCount;
    logic shiftEn;
    logic frameDone;
    logic wordFull;
    logic loadEn;
    logic [sdc_pkg::NUM_CHANNELS-1:0] writeHit;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************

    // Gather pins into one group
    assign pinLevel.serialClk = serialClk;
    assign pinLevel.chipSelectN = chipSelectN;
    assign pinLevel.serialInLine = serialInLine;
    assign pinLevel.powerDownN = powerDownN;
    assign pinLevel.midscalePresetN = midscalePresetN;

    sdc_link_sync u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pinLevel(pinLevel),
        .syncLevel(lvl),
        .clkRise(clkRise),
        .csRise(csRise)
    );

    // ****************************************************************
    // Frame tracking
    // ****************************************************************

    // Next frame state from chip select level and rise
    always_comb begin
        next_frameState = frameState;
        unique case (frameState)
            sdc_pkg::FRAME_IDLE: begin
                if (!lvl.chipSelectN) begin
                    next_frameState = sdc_pkg::FRAME_SHIFT;
                end
            end
            sdc_pkg::FRAME_SHIFT: begin
                if (csRise) begin
                    next_frameState = sdc_pkg::FRAME_IDLE;
                end
            end
            default: begin
                next_frameState = sdc_pkg::FRAME_IDLE;
            end
        endcase
    end

    // Frame state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            frameState <= sdc_pkg::FRAME_IDLE;
        end else begin
            frameState <= next_frameState;
        end
    end

    // Shift only inside a frame with select low
    assign shiftEn = (frameState == sdc_pkg::FRAME_SHIFT) && !lvl.chipSelectN && clkRise;
    // Frame ends on select rise; a clock edge there shifts nothing
    assign frameDone = (frameState == sdc_pkg::FRAME_SHIFT) && csRise;

    // ****************************************************************
    // Serial input register
    // ****************************************************************

    // Shift MSB first; oldest bit falls off the top
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            shiftWord <= sdc_pkg::WORD_RESET;
        end else if (shiftEn) begin
            shiftWord <= {shiftWord[sdc_pkg::WORD_TOP_BIT-1:0], lvl.serialInLine};
        end
    end

    // Count bits of this frame, saturating at one word
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bitCount <= sdc_pkg::COUNT_RESET;
        end else if (frameState == sdc_pkg::FRAME_IDLE) begin
            bitCount <= sdc_pkg::COUNT_RESET;
        end else if (shiftEn && !wordFull) begin
            bitCount <= bitCount + sdc_pkg::ADDR_BITS'(1);
        end
    end

    assign wordFull = (bitCount == sdc_pkg::ADDR_BITS'(sdc_pkg::WORD_BITS));

    // ****************************************************************
    // Address decode and load
    // ****************************************************************

    // Load needs a full word, no shutdown and no preset
    assign loadEn = frameDone && wordFull && lvl.powerDownN && lvl.midscalePresetN;

    // One channel for addresses 0 to 11, none above
    assign writeHit = loadEn ? sdc_pkg::channel_hit(shiftWord.addr) : '0;

    // Channel registers; preset acts without a clock edge
    always_ff @(posedge sys_clk or negedge midscalePresetN) begin
        if (!midscalePresetN) begin
            channelCode <= sdc_pkg::CODES_PRESET;
        end else if (!rstn) begin
            channelCode <= sdc_pkg::CODES_PRESET;
        end else begin
            for (int i = 0; i < sdc_pkg::NUM_CHANNELS; i++) begin
                if (writeHit[i]) begin
                    channelCode[i] <= shiftWord.code;
                end
            end
        end
    end

    // Load strobe mirrors the channel written
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            loadPulse <= '0;
        end else begin
            loadPulse <= writeHit;
        end
    end

    // ****************************************************************
    // Shutdown output control
    // ****************************************************************

    // Outputs open while shutdown holds; codes are kept
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            outputEnable <= '0;
        end else begin
            outputEnable <= {sdc_pkg::NUM_CHANNELS{lvl.powerDownN}};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // New bit enters at the bottom on each shift
    shift_step_a: assert property (
        shiftEn |=> shiftWord[0] == $past(lvl.serialInLine))
        else $error("shift register did not take the data bit");

    // Older bits move up; the top bit is dropped
    older_drop_a: assert property (
        shiftEn |=> shiftWord[sdc_pkg::WORD_TOP_BIT:1] ==
            $past(shiftWord[sdc_pkg::WORD_TOP_BIT-1:0]))
        else $error("shift register did not move up by one");

    // No shifting while select is high
    select_idle_a: assert property (
        lvl.chipSelectN && !shiftEn |=> $stable(shiftWord))
        else $error("shift register changed while deselected");

    // Load strobe names the decoded channel
    addr_decode_a: assert property (
        loadEn |=> loadPulse == sdc_pkg::channel_hit($past(shiftWord.addr)))
        else $error("wrong channel strobed for address");

    // Last channel address hits the last channel, not the first
    channel_ends_a: assert property (
        loadEn && shiftWord.addr == 4'hb |=> loadPulse[sdc_pkg::NUM_CHANNELS-1] && !loadPulse[0])
        else $error("address eleven did not reach the last channel");

    // Strobe only after a frame end, at most one channel
    load_edge_a: assert property (
        loadPulse != '0 |-> $past(frameDone) && $onehot(loadPulse))
        else $error("load without a frame end or more than one channel");

    // Unmapped addresses write nothing
    unmapped_addr_a: assert property (
        loadEn && shiftWord.addr >= sdc_pkg::ADDR_BITS'(sdc_pkg::NUM_CHANNELS) |=> loadPulse == '0)
        else $error("unmapped address loaded a channel");

    // Shutdown freezes every code
    shutdown_hold_a: assert property (
        !lvl.powerDownN && midscalePresetN ##1 midscalePresetN |-> $stable(channelCode))
        else $error("channel code changed during shutdown");

    // Outputs follow the synchronised shutdown level
    outputs_open_a: assert property (
        1'b1 |=> outputEnable == {sdc_pkg::NUM_CHANNELS{$past(lvl.powerDownN)}})
        else $error("outputs not opened or restored with shutdown");

    // Held preset keeps every channel at midscale
    preset_mid_a: assert property (
        !midscalePresetN ##1 !midscalePresetN |-> channelCode == sdc_pkg::CODES_PRESET)
        else $error("preset held but channels not at midscale");

    // Per channel: unwritten codes kept, written code captured
    generate
        for (genvar g = 0; g < sdc_pkg::NUM_CHANNELS; g++) begin : g_keep
            others_kept_a: assert property (
                !writeHit[g] && midscalePresetN ##1 midscalePresetN |-> $stable(channelCode[g]))
                else $error("channel changed without being addressed");
            code_capture_a: assert property (
                loadPulse[g] && midscalePresetN |-> channelCode[g] == $past(shiftWord.code))
                else $error("channel did not capture the code field");
        end
    endgenerate

    // ****************************************************************
    // Frame, counter, load and preset checks
    // ****************************************************************

    // Channel one answers to address zero
    first_channel_a: assert property (
        loadEn && shiftWord.addr == '0 |=> loadPulse[0] && !loadPulse[sdc_pkg::NUM_CHANNELS-1])
        else $error("address zero did not reach the first channel");

    // Preset low means midscale at once, no edge needed
    preset_async_a: assert property (
        !midscalePresetN |-> channelCode == sdc_pkg::CODES_PRESET)
        else $error("preset low but channels not at midscale");

    // Shutdown drops a finished frame
    shutdown_block_a: assert property (
        frameDone && !lvl.powerDownN |=> loadPulse == '0)
        else $error("frame loaded a channel during shutdown");

    // Preset drops a finished frame
    preset_block_a: assert property (
        frameDone && !lvl.midscalePresetN |=> loadPulse == '0)
        else $error("frame loaded a channel while preset held");

    // Deselected cycles without a frame end load nothing
    deselect_quiet_a: assert property (
        lvl.chipSelectN && !frameDone |=> loadPulse == '0)
        else $error("load strobe without a chip select rise");

    // Load strobe lasts one cycle
    pulse_single_a: assert property (
        loadPulse != '0 |=> loadPulse == '0)
        else $error("load strobe longer than one cycle");

    // Frame closes on select rise
    frame_close_a: assert property (
        frameDone |=> frameState == sdc_pkg::FRAME_IDLE)
        else $error("frame did not close on chip select rise");

    // Select low opens a frame
    frame_open_a: assert property (
        !lvl.chipSelectN && frameState == sdc_pkg::FRAME_IDLE |=>
            frameState == sdc_pkg::FRAME_SHIFT)
        else $error("frame did not open on chip select low");

    // Frame state code stays one-hot
    frame_code_a: assert property (
        $onehot(frameState))
        else $error("frame state code not one-hot");

    // Load only after a full word
    word_full_a: assert property (
        loadPulse != '0 |-> $past(wordFull))
        else $error("load from a frame shorter than one word");

    // Bit count never passes one word
    count_limit_a: assert property (
        bitCount <= sdc_pkg::ADDR_BITS'(sdc_pkg::WORD_BITS))
        else $error("bit count ran past one word");

    // Each shift below a full word adds one to the count
    count_step_a: assert property (
        shiftEn && !wordFull |=> bitCount == $past(bitCount) + sdc_pkg::ADDR_BITS'(1))
        else $error("bit count did not follow the shifts");

    // Count restarts outside a frame
    count_clear_a: assert property (
        frameState == sdc_pkg::FRAME_IDLE |=> bitCount == sdc_pkg::COUNT_RESET)
        else $error("bit count not cleared between frames");

    // Main scenarios
    first_write_c: cover property (writeHit[0]);
    last_write_c: cover property (writeHit[sdc_pkg::NUM_CHANNELS-1]);
    unmapped_c: cover property (frameDone && wordFull && shiftWord.addr == 4'hf);
    shutdown_frame_c: cover property (frameDone && wordFull && !lvl.powerDownN);
    preset_release_c: cover property (!midscalePresetN ##1 midscalePresetN);

endmodule // sdc_dac_ctrl

/* hw/sdc_pkg.sv */
package sdc_pkg;

// ****************************************************************
// Overview of operation
// - Word is 12 bits, MSB first: 4-bit address, then 8-bit code.
// - Address value plus one names the channel receiving the code.
// - Channels are written singly, any order; others stay unchanged.
// - Chip select low: each serial clock rise shifts in one data bit.
// - Only the last 12 bits shifted in count at chip select rise.
// - Chip select rise enables decoder, loading at most one channel.
// - Selected channel takes the low eight bits of the word.
// - Each channel holds its own 8-bit code until overwritten.
// - Preset input forces every channel to midscale, decimal 128.
// - Shutdown asserted keeps all channel registers unchanged.
// - Shutdown opens all outputs; leaving it restores retained codes.
// - Preset acts without any clock and loads hex 80 everywhere.
// - Address 0000 is channel one, 1011 channel twelve, ascending.
// ****************************************************************

// ****************************************************************
// Word and channel layout
// ****************************************************************
localparam int NUM_CHANNELS = 12;
localparam int WORD_BITS = 12;
localparam int WORD_TOP_BIT = 11;
localparam int ADDR_BITS = 4;
localparam int CODE_BITS = 8;
localparam logic [CODE_BITS-1:0] MIDSCALE_CODE = 8'h80;
localparam logic [WORD_BITS-1:0] WORD_RESET = 12'h000;
localparam logic [ADDR_BITS-1:0] COUNT_RESET = 4'h0;

// Received word, address in the top bits
typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [CODE_BITS-1:0] code;
} sdc_word_t;

// All channel codes, channel one at index 0
typedef logic [NUM_CHANNELS-1:0][CODE_BITS-1:0] sdc_codes_t;

localparam sdc_codes_t CODES_PRESET = {NUM_CHANNELS{MIDSCALE_CODE}};

// ****************************************************************
// Pin group crossing into the system clock
// ****************************************************************
typedef struct packed {
    logic serialClk;
    logic chipSelectN;
    logic serialInLine;
    logic powerDownN;
    logic midscalePresetN;
} sdc_link_t;

// Idle levels: clock high, deselected, data low, running, no preset
localparam sdc_link_t LINK_IDLE = 5'h1b;

// Frame tracking states
typedef enum logic [1:0] {
    FRAME_IDLE = 2'b01,
    FRAME_SHIFT = 2'b10
} sdc_frame_t;

// One-hot channel hit for an address, none for unmapped codes
function automatic logic [NUM_CHANNELS-1:0] channel_hit(input logic [ADDR_BITS-1:0] addr);
    logic [NUM_CHANNELS-1:0] hit;
    hit = '0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
        hit[i] = (addr == ADDR_BITS'(i));
    end
    return hit;
endfunction

endpackage

/* hw/sdc_link_sync.sv */
module sdc_link_sync (
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire sdc_pkg::sdc_link_t pinLevel, // Raw pin levels
    output sdc_pkg::sdc_link_t syncLevel, // Levels after two flops
    output logic clkRise, // Serial clock rose
    output logic csRise // Chip select returned high
);

    sdc_pkg::sdc_link_t stage1;
    sdc_pkg::sdc_link_t prevLevel;

    // Two-flop synchroniser plus history stage for edges
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stage1 <= sdc_pkg::LINK_IDLE;
            syncLevel <= sdc_pkg::LINK_IDLE;
            prevLevel <= sdc_pkg::LINK_IDLE;
        end else begin
            stage1 <= pinLevel;
            syncLevel <= stage1;
            prevLevel <= syncLevel;
        end
    end

    // Edges from settled stages only
    assign clkRise = syncLevel.serialClk & ~prevLevel.serialClk;
    assign csRise = syncLevel.chipSelectN & ~prevLevel.chipSelectN;

endmodule // sdc_link_sync

/* verif/sdc_host_model.sv */
// ****************************************************************
// Serial master standing in for the host controller
// ****************************************************************
module sdc_host_model (
    input wire logic sysClk, // Pacing clock for pin changes
    output logic serialClk, // Serial clock, idles high
    output logic chipSelectN, // Chip select, active low
    output logic serialInLine // Serial data, MSB first
);
    timeunit 1ns;
    timeprecision 100ps;

    int halfCycles = 4; // Cycles per serial clock phase

    // Idle pins: clock parked high, deselected
    initial begin
        serialClk = 1'b1;
        chipSelectN = 1'b1;
        serialInLine = 1'b0;
    end

    // Wait whole cycles on the falling edge
    task automatic idle(input int n);
        repeat (n) @(negedge sysClk);
    endtask

    // Data set with clock low, taken on the rise
    task automatic shift_bit(input logic b);
        serialClk = 1'b0;
        serialInLine = b;
        idle(halfCycles);
        serialClk = 1'b1;
        idle(halfCycles);
    endtask

    // Select, then one clock phase of setup
    task automatic begin_frame();
        @(negedge sysClk);
        chipSelectN = 1'b0;
        idle(halfCycles);
    endtask

    // Deselect with clock still high; data line no longer valid
    task automatic end_frame();
        chipSelectN = 1'b1;
        serialInLine = ~serialInLine;
    endtask

    // Twelve-bit word, top bit first
    task automatic send_word(input logic [11:0] w);
        begin_frame();
        for (int i = 11; i >= 0; i--) begin
            shift_bit(w[i]);
        end
        end_frame();
    endtask

    // Sixteen-bit word, as byte-oriented hosts send
    task automatic send_long(input logic [15:0] w);
        begin_frame();
        for (int i = 15; i >= 0; i--) begin
            shift_bit(w[i]);
        end
        end_frame();
    endtask
endmodule // sdc_host_model

/* verif/sdc_dac_ctrl_bench.sv */
// ****************************************************************
// Self-checking bench for the channel code controller
// ****************************************************************
module sdc_dac_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic sysClk = 1'b0;
    logic rstn = 1'b0;
    logic midscalePresetN = 1'b1;
    logic powerDownN = 1'b1;
    logic serialClk;
    logic chipSelectN;
    logic serialInLine;
    sdc_pkg::sdc_codes_t channelCode;
    logic [sdc_pkg::NUM_CHANNELS-1:0] outputEnable;
    logic [sdc_pkg::NUM_CHANNELS-1:0] loadPulse;
    sdc_pkg::sdc_codes_t expCodes = sdc_pkg::CODES_PRESET;
    int errTotal = 0;
    int compares = 0;

    // 40 MHz system clock
    always #12.5 sysClk = ~sysClk;

    sdc_dac_ctrl i_sdc_dac_ctrl (
        .sys_clk(sysClk),
        .rstn(rstn),
        .serialClk(serialClk),
        .chipSelectN(chipSelectN),
        .serialInLine(serialInLine),
        .midscalePresetN(midscalePresetN),
        .powerDownN(powerDownN),
        .channelCode(channelCode),
        .outputEnable(outputEnable),
        .loadPulse(loadPulse)
    );

    sdc_host_model i_sdc_host_model (
        .sysClk(sysClk),
        .serialClk(serialClk),
        .chipSelectN(chipSelectN),
        .serialInLine(serialInLine)
    );

    // Compare and count
    task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic finalReport();
        $display("Comparisons %0d, mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Wait for a load (mask zero: none), then check codes and pulse width
    task automatic expect_load(input logic [11:0] mask);
        int n;
        n = 0;
        while (loadPulse === 12'h000 && n < 20) begin
            @(negedge sysClk);
            n++;
        end
        check("loadPulse", loadPulse, mask);
        check("channelCode", channelCode, expCodes);
        @(negedge sysClk);
        check("loadPulse after", loadPulse, 12'h000);
    endtask

    // One word to one mapped channel
    task automatic write_chan(input int ch, input logic [7:0] code);
        expCodes[ch] = code;
        i_sdc_host_model.send_word({4'(ch), code});
        expect_load(12'(1) << ch);
    endtask

    task automatic test_reset();
        repeat (6) @(negedge sysClk);
        check("reset codes", channelCode, sdc_pkg::CODES_PRESET);
        check("reset enable", outputEnable, 12'hfff);
        check("reset pulse", loadPulse, 12'h000);
    endtask

    // Every channel, descending order
    task automatic test_all_channels();
        for (int i = 11; i >= 0; i--) begin
            write_chan(i, 8'(8'h11 * i + 8'h0f));
        end
    endtask

    // Sixteen bits: leading nibble maps nothing, last twelve count
    task automatic test_long_frame();
        expCodes[5] = 8'hff;
        i_sdc_host_model.send_long(16'hc5ff);
        expect_load(12'h020);
    endtask

    task automatic test_unmapped();
        for (int a = 12; a < 16; a++) begin
            i_sdc_host_model.send_word({4'(a), 8'h5a});
            expect_load(12'h000);
        end
    endtask

    task automatic test_shutdown();
        @(negedge sysClk);
        powerDownN = 1'b0;
        repeat (6) @(negedge sysClk);
        check("shutdown enable", outputEnable, 12'h000);
        i_sdc_host_model.send_word({4'h3, 8'h77});
        expect_load(12'h000);
        powerDownN = 1'b1;
        repeat (6) @(negedge sysClk);
        check("wake enable", outputEnable, 12'hfff);
        check("wake codes", channelCode, expCodes);
    endtask

    task automatic test_preset();
        @(negedge sysClk);
        midscalePresetN = 1'b0;
        #1;
        check("preset codes", channelCode, sdc_pkg::CODES_PRESET);
        expCodes = sdc_pkg::CODES_PRESET;
        i_sdc_host_model.send_word({4'h2, 8'h33});
        expect_load(12'h000);
        midscalePresetN = 1'b1;
        repeat (4) @(negedge sysClk);
        write_chan(2, 8'h33);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge sysClk);
        errTotal++;
        $display("Watchdog expired");
        finalReport();
    end

    // Main sequence
    initial begin
        repeat (12) @(negedge sysClk);
        rstn = 1'b1;
        test_reset();
        test_all_channels();
        test_long_frame();
        test_unmapped();
        test_shutdown();
        test_preset();
        finalReport();
    end
endmodule // sdc_dac_ctrl_bench
